//--- verilog/rx_irq_enable.v
// Purpose: receive holding registers, event flags and gated interrupt
// Assumes: register port is the decoded host serial port, one byte wide
// Notes: read data is registered and valid the cycle after the strobe
`timescale 1ns/100ps
`include "rx_irq_defs.vh"

module rx_irq_enable #(
  parameter CHANNELS = 2
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire [CHANNELS-1:0] bit_valid_i,
  input wire [CHANNELS-1:0] bit_invalid_i,
  input wire [CHANNELS-1:0] bit_data_i,
  output wire irq_o,
  output wire eof_irq_o
);

  // ****************************************
  // decode helpers
  // ****************************************
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  function [7:0] data_addr;
    input integer ch;
    begin
      data_addr = (ch == 0) ? `ADDR_RX_DATA_A : `ADDR_RX_DATA_B;
    end
  endfunction

  // ****************************************
  // control registers
  // ****************************************
  reg [`SER_CTRL_BITS-1:0] ser_ctrl_reg;
  reg [7:0] irq_en_reg;
  wire [2:0] gap_len;
  wire stat_rd;

  assign gap_len = ser_ctrl_reg[`GAP_MSB:`GAP_LSB];
  assign stat_rd = reg_rd_i && hit(reg_addr_i, `ADDR_RX_IRQ_STAT);

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ser_ctrl_reg <= `SER_CTRL_RST;
      irq_en_reg <= `RX_IRQ_EN_RST;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, `ADDR_SER_CTRL))
        ser_ctrl_reg <= reg_wdata_i[`SER_CTRL_BITS-1:0];
      if (hit(reg_addr_i, `ADDR_RX_IRQ_EN))
        irq_en_reg <= reg_wdata_i;
    end
  end

  // ****************************************
  // per channel holding register and flags
  // ****************************************
  wire [8*CHANNELS-1:0] hold_data;
  wire [4*CHANNELS-1:0] stat_nib;
  wire [CHANNELS-1:0] req;
  wire [CHANNELS-1:0] eof_req;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : ch
      wire load;
      wire [7:0] load_data;
      wire load_all_valid;
      wire eof_evt;
      wire data_rd;
      wire [3:0] en;
      reg [7:0] hold_reg;
      reg full_reg;
      reg valid_reg;
      reg ovf_reg;
      reg udf_reg;
      reg eof_reg;

      rx_byte_assembler asm_i (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .gap_len_i(gap_len),
        .bit_valid_i(bit_valid_i[g]),
        .bit_invalid_i(bit_invalid_i[g]),
        .bit_data_i(bit_data_i[g]),
        .load_o(load),
        .load_data_o(load_data),
        .load_all_valid_o(load_all_valid),
        .eof_o(eof_evt)
      );

      assign data_rd = reg_rd_i && hit(reg_addr_i, data_addr(g));
      assign en = irq_en_reg[`CH_NIBBLE*g +: `CH_NIBBLE];

      always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          hold_reg <= 8'h00;
          full_reg <= 1'b0;
          valid_reg <= 1'b0;
        end else begin
          if (load) begin
            hold_reg <= load_data;
            full_reg <= 1'b1;
            valid_reg <= load_all_valid;
          end else if (data_rd) begin
            full_reg <= 1'b0;
          end
        end
      end

      // flags: a new event in the clearing cycle survives the clear
      always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          ovf_reg <= 1'b0;
          udf_reg <= 1'b0;
          eof_reg <= 1'b0;
        end else begin
          // load over unread byte
          // a read in the same cycle takes the old byte first
          if (load && full_reg && !data_rd)
            ovf_reg <= 1'b1;
          else if (stat_rd)
            ovf_reg <= 1'b0;
          if (data_rd && !full_reg)
            udf_reg <= 1'b1;
          else if (stat_rd)
            udf_reg <= 1'b0;
          if (eof_evt)
            eof_reg <= 1'b1;
          else if (stat_rd)
            eof_reg <= 1'b0;
        end
      end

      assign hold_data[8*g +: 8] = hold_reg;
      assign stat_nib[4*g +: 4] = {valid_reg, ovf_reg | udf_reg,
                                   eof_reg, full_reg};
      assign req[g] = (en[`FLD_UDF] & udf_reg) |
                      (en[`FLD_OVF] & ovf_reg) |
                      (en[`FLD_EOF] & eof_reg) |
                      (en[`FLD_FULL] & full_reg);
      assign eof_req[g] = en[`FLD_EOF] & eof_reg;
    end
  endgenerate

  // ****************************************
  // interrupt outputs
  // ****************************************
  // or of enabled pending
  assign irq_o = |req;
  assign eof_irq_o = |eof_req;

  // ****************************************
  // read data path
  // ****************************************
  reg [7:0] rdata_next;

  always @* begin
    rdata_next = 8'h00;
    case (reg_addr_i)
      `ADDR_SER_CTRL: rdata_next = {4'h0, ser_ctrl_reg};
      `ADDR_RX_IRQ_EN: rdata_next = irq_en_reg;
      `ADDR_RX_IRQ_STAT: rdata_next = stat_nib[7:0];
      `ADDR_RX_DATA_A: rdata_next = hold_data[7:0];
      `ADDR_RX_DATA_B: rdata_next = hold_data[15:8];
      default: rdata_next = 8'h00;
    endcase
  end

  // unmapped reads answer zero so the host never sees stale bytes
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= rdata_next;
  end

endmodule

//--- verilog/rx_irq_defs.vh
// Purpose: register map, fields and reset values of the receive irq block
// Assumes: eight-bit register port, offsets are byte addresses
// Notes: channel B fields sit four bits above the channel A fields
//
// Contract
// - enable bit 7 gates the channel B underflow interrupt.
// - reading empty channel B data register flags channel B underflow.
// - enable bit 6 gates the channel B overflow interrupt.
// - loading channel B holding register while unread flags channel B overflow.
// - enable bit 5 gates the channel B end-of-frame interrupt.
// - end-of-frame needs a valid bit, then invalid bit count exceeding gap.
// - gap length zero gives end-of-frame at the first invalid bit.
// - request asserts while an enabled end-of-frame is pending on either channel.
// - reading the status register clears the end-of-frame request.
// - enable bit 4 gates the channel B full interrupt.
// - full occurs on every load: complete byte or end-of-frame partial byte.
// - enable bit 3 gates the channel A underflow interrupt.
// - reading empty channel A data register flags channel A underflow.
// - enable bit 2 gates channel A overflow; loading unread register flags it.
// - enable bit 1 gates the channel A end-of-frame interrupt.
// - enable bit 0 gates the channel A full interrupt.
// - gap length is bits 2 to 0 of the serial-data control register.
// - status register read clears pending flow-violation and end-of-frame flags.

`ifndef RX_IRQ_DEFS_VH
`define RX_IRQ_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define ADDR_SER_CTRL 8'h06
`define ADDR_RX_IRQ_EN 8'h07
`define ADDR_RX_IRQ_STAT 8'h08
`define ADDR_RX_DATA_A 8'h09
`define ADDR_RX_DATA_B 8'h0B

// ****************************************
// reset values
// ****************************************
`define SER_CTRL_RST 4'h3
`define RX_IRQ_EN_RST 8'h00

// ****************************************
// field positions
// ****************************************
`define GAP_MSB 2
`define GAP_LSB 0
`define SER_CTRL_BITS 4
`define CH_NIBBLE 4
`define FLD_FULL 0
`define FLD_EOF 1
`define FLD_OVF 2
`define FLD_UDF 3
`define STAT_FULL 0
`define STAT_EOF 1
`define STAT_FLOW 2
`define STAT_VALID 3

// ****************************************
// counts
// ****************************************
`define BYTE_BITS 4'h8

`endif

//--- verilog/rx_byte_assembler.v
// Purpose: gathers received bits into bytes and detects end of frame
// Assumes: bit strobes come from the correlator on the same clock
// Notes: bits arrive lsb first; a partial byte is left in the upper bits
`timescale 1ns/100ps
`include "rx_irq_defs.vh"

module rx_byte_assembler (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [2:0] gap_len_i,
  input wire bit_valid_i,
  input wire bit_invalid_i,
  input wire bit_data_i,
  output reg load_o,
  output reg [7:0] load_data_o,
  output reg load_all_valid_o,
  output reg eof_o
);

  reg [7:0] shift_reg;
  reg [3:0] nbits_reg;
  reg [3:0] gap_cnt_reg;
  reg in_frame_reg;
  reg [7:0] shift_next;
  reg [3:0] gap_next;

  // ****************************************
  // bit assembly and gap counting
  // ****************************************
  always @* begin
    shift_next = {bit_data_i, shift_reg[7:1]};
    gap_next = gap_cnt_reg + 4'h1;
  end

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= 8'h00;
      nbits_reg <= 4'h0;
      gap_cnt_reg <= 4'h0;
      in_frame_reg <= 1'b0;
      load_o <= 1'b0;
      load_data_o <= 8'h00;
      load_all_valid_o <= 1'b0;
      eof_o <= 1'b0;
    end else begin
      load_o <= 1'b0;
      eof_o <= 1'b0;
      // a valid bit wins over a coincident invalid strobe
      if (bit_valid_i) begin
        in_frame_reg <= 1'b1;
        gap_cnt_reg <= 4'h0;
        if (nbits_reg == `BYTE_BITS - 4'h1) begin
          load_o <= 1'b1;
          load_data_o <= shift_next;
          load_all_valid_o <= 1'b1;
          nbits_reg <= 4'h0;
          shift_reg <= 8'h00;
        end else begin
          nbits_reg <= nbits_reg + 4'h1;
          shift_reg <= shift_next;
        end
      end else if (bit_invalid_i && in_frame_reg) begin
        if (gap_next > {1'b0, gap_len_i}) begin
          eof_o <= 1'b1;
          in_frame_reg <= 1'b0;
          gap_cnt_reg <= 4'h0;
          nbits_reg <= 4'h0;
          shift_reg <= 8'h00;
          if (nbits_reg != 4'h0) begin
            load_o <= 1'b1;
            load_data_o <= shift_reg;
            load_all_valid_o <= 1'b0;
          end
        end else begin
          gap_cnt_reg <= gap_next;
        end
      end
    end
  end

endmodule

//--- testbench/rx_irq_checker.sv
// Purpose: port-level checks of the receive irq block
// Assumes: single clock, async active-high reset
// Notes: enable register is shadowed from the write strobe
`timescale 1ns/100ps
module rx_irq_checker #(
  parameter CHANNELS = 2
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire [CHANNELS-1:0] bit_invalid_i,
  input wire irq_o,
  input wire eof_irq_o
);
  reg [7:0] en_reg;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) en_reg <= 8'h00;
    else if (reg_wr_i && reg_addr_i == 8'h07) en_reg <= reg_wdata_i;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  chk_eof_in_irq: assert property (eof_irq_o |-> irq_o)
    else $error("eof request without irq");
  chk_irq_masked: assert property (en_reg == 8'h00 |-> !irq_o)
    else $error("irq with all enables off");
  chk_eof_masked: assert property (
    !en_reg[5] && !en_reg[1] |-> !eof_irq_o)
    else $error("eof request while masked");
  chk_stat_clear: assert property (reg_rd_i && reg_addr_i == 8'h08 &&
    $past(bit_invalid_i) == 0 |=> !eof_irq_o)
    else $error("eof request kept after status read");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  chk_en_readback: assert property (reg_rd_i && reg_addr_i == 8'h07
    |=> reg_rdata_o == $past(en_reg))
    else $error("enable readback wrong");
  chk_gap_upper: assert property (reg_rd_i && reg_addr_i == 8'h06
    |=> reg_rdata_o[7:4] == 4'h0)
    else $error("serial control upper bits set");
  chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 8'h0B
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind rx_irq_enable rx_irq_checker #(.CHANNELS(CHANNELS)) chk_i (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .bit_invalid_i(bit_invalid_i),
  .irq_o(irq_o), .eof_irq_o(eof_irq_o));

//--- testbench/bit_source.sv
// Purpose: correlator-side model giving bit strobes per channel
// Assumes: strobes change 1 ns after the rising edge
// Notes: data line toggles on each invalid strobe and once after a run of valid bits
`timescale 1ns/100ps
module bit_source (
  input wire sys_clk_i,
  output reg [1:0] bit_valid_o,
  output reg [1:0] bit_invalid_o,
  output reg [1:0] bit_data_o
);
  initial begin
    bit_valid_o = 2'h0;
    bit_invalid_o = 2'h0;
    bit_data_o = 2'h0;
  end
  // lsb first, one strobe a cycle
  task bits(input integer ch, input integer n, input [7:0] d);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      @(posedge sys_clk_i) #1 bit_valid_o[ch] = 1'b1;
      bit_data_o[ch] = d[i];
    end
    @(posedge sys_clk_i) #1 bit_valid_o[ch] = 1'b0;
    bit_data_o[ch] = ~bit_data_o[ch];
  endtask
  task idle(input integer ch, input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      @(posedge sys_clk_i) #1 bit_invalid_o[ch] = 1'b1;
      bit_data_o[ch] = ~bit_data_o[ch];
    end
    @(posedge sys_clk_i) #1 bit_invalid_o[ch] = 1'b0;
  endtask
endmodule

//--- testbench/rx_irq_enable_tb.sv
// Purpose: self-checking bench of the receive irq block
// Assumes: inputs driven 1 ns after the rising edge
// Notes: flags are checked three cycles after the last strobe
`timescale 1ns/100ps
`include "rx_irq_defs.vh"
module rx_irq_enable_tb;
  reg sys_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdat = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [7:0] got;
  wire [7:0] rdata;
  wire [1:0] bv, bi, bd;
  wire irq, eirq;
  integer err_total = 0;
  integer checks_done = 0;
  integer cyc = 0;
  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  bit_source src (.sys_clk_i(sys_clk_i), .bit_valid_o(bv),
    .bit_invalid_o(bi), .bit_data_o(bd));
  rx_irq_enable #(.CHANNELS(2)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .bit_valid_i(bv), .bit_invalid_i(bi),
    .bit_data_i(bd), .irq_o(irq), .eof_irq_o(eirq));
  task chk(input string nm, input [7:0] e, input [7:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wreg(input [7:0] a, input [7:0] d);
    @(posedge sys_clk_i) #1 addr = a;
    wdat = d;
    wr = 1'b1;
    @(posedge sys_clk_i) #1 wr = 1'b0;
  endtask
  task rreg(input [7:0] a);
    @(posedge sys_clk_i) #1 addr = a;
    rd = 1'b1;
    @(posedge sys_clk_i) #1 rd = 1'b0;
    got = rdata;
  endtask
  task settle;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask
  task t_regs;
    rreg(`ADDR_RX_IRQ_EN);
    chk("en", `RX_IRQ_EN_RST, got);
    rreg(`ADDR_SER_CTRL);
    chk("ser", {4'h0, `SER_CTRL_RST}, got);
    wreg(`ADDR_RX_IRQ_EN, 8'hA5);
    rreg(`ADDR_RX_IRQ_EN);
    chk("en", 8'hA5, got);
    rreg(8'h20);
    chk("unmapped", 8'h00, got);
    wreg(`ADDR_RX_IRQ_EN, 8'h00);
    $display("test regs done");
  endtask
  task t_full_a;
    wreg(`ADDR_RX_IRQ_EN, 8'h01);
    src.bits(0, 8, 8'h5A);
    settle;
    chk("irq", 8'h01, {7'h00, irq});
    rreg(`ADDR_RX_IRQ_STAT);
    chk("stat", 8'h09, got);
    rreg(`ADDR_RX_DATA_A);
    chk("data", 8'h5A, got);
    chk("irq", 8'h00, {7'h00, irq});
    wreg(`ADDR_RX_IRQ_EN, 8'h08);
    rreg(`ADDR_RX_DATA_A);
    #1;
    chk("irq", 8'h01, {7'h00, irq});
    wreg(`ADDR_RX_IRQ_EN, 8'h04);
    #1;
    chk("irq", 8'h00, {7'h00, irq});
    rreg(`ADDR_RX_IRQ_STAT);
    chk("stat", 8'h0C, got);
    wreg(`ADDR_RX_IRQ_EN, 8'h08);
    #1;
    chk("irq", 8'h00, {7'h00, irq});
    $display("test full a done");
  endtask
  task t_ovf_b;
    wreg(`ADDR_RX_IRQ_EN, 8'h40);
    src.bits(1, 8, 8'h3C);
    src.bits(1, 8, 8'hC3);
    settle;
    chk("irq", 8'h01, {7'h00, irq});
    wreg(`ADDR_RX_IRQ_EN, 8'h10);
    #1;
    chk("irq", 8'h01, {7'h00, irq});
    wreg(`ADDR_RX_IRQ_EN, 8'h40);
    rreg(`ADDR_RX_IRQ_STAT);
    chk("stat", 8'hD8, got);
    chk("irq", 8'h00, {7'h00, irq});
    rreg(`ADDR_RX_DATA_B);
    chk("data", 8'hC3, got);
    // channel B is still in its frame: close it with the reset gap of 3
    src.idle(1, 4);
    settle;
    chk("eof", 8'h00, {7'h00, eirq});
    rreg(`ADDR_RX_IRQ_STAT);
    chk("stat", 8'hA8, got);
    $display("test ovf b done");
  endtask
  task t_eof;
    wreg(`ADDR_SER_CTRL, 8'h00);
    wreg(`ADDR_RX_IRQ_EN, 8'h22);
    src.bits(0, 3, 8'h05);
    src.idle(0, 1);
    settle;
    chk("eof", 8'h01, {7'h00, eirq});
    rreg(`ADDR_RX_IRQ_STAT);
    chk("stat", 8'h83, got);
    chk("eof", 8'h00, {7'h00, eirq});
    rreg(`ADDR_RX_DATA_A);
    chk("data", 8'hA0, got);
    wreg(`ADDR_SER_CTRL, 8'h02);
    src.idle(1, 3);
    settle;
    chk("eof", 8'h00, {7'h00, eirq});
    src.bits(1, 1, 8'h01);
    src.idle(1, 2);
    settle;
    chk("eof", 8'h00, {7'h00, eirq});
    src.idle(1, 1);
    settle;
    chk("eof", 8'h01, {7'h00, eirq});
    rreg(`ADDR_RX_DATA_B);
    chk("data", 8'h80, got);
    $display("test eof done");
  endtask
  task t_flow;
    rreg(`ADDR_RX_IRQ_STAT);
    chk("stat", 8'h20, got);
    wreg(`ADDR_RX_IRQ_EN, 8'h80);
    rreg(`ADDR_RX_DATA_B);
    #1;
    chk("irq", 8'h01, {7'h00, irq});
    wreg(`ADDR_RX_IRQ_EN, 8'h04);
    #1;
    chk("irq", 8'h00, {7'h00, irq});
    src.bits(0, 8, 8'h11);
    src.bits(0, 8, 8'h22);
    settle;
    chk("irq", 8'h01, {7'h00, irq});
    rreg(`ADDR_RX_IRQ_STAT);
    chk("stat", 8'h4D, got);
    chk("irq", 8'h00, {7'h00, irq});
    $display("test flow done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, tests need well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    t_regs;
    t_full_a;
    t_ovf_b;
    t_eof;
    t_flow;
    tally_and_finish;
  end
endmodule
